// ===== rtl/logic_block.v
`timescale 1ns/1ps
`default_nettype none
`include "logic_block_defs.vh"
module logic_block #(
  parameter NIN = 33, // Inputs from the central matrix
  parameter NISM = 24 // Signals sent back to the central matrix
) (
  input wire aclk, // System clock, 100 MHz
  input wire aresetn, // Synchronous reset, active low
  input wire [11:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output wire [1:0] s_axi_bresp, // Write response
  output wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [11:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output wire [31:0] s_axi_rdata, // Read data
  output wire [1:0] s_axi_rresp, // Read response
  output wire s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire [NIN-1:0] csm_in, // Signals from the central matrix
  input wire [3:0] gclk_pin, // Global clock pins
  input wire [7:0] pin_i, // Pin cell input levels
  output wire [7:0] pin_o, // Pin cell output values
  output wire [7:0] pin_oe_n, // Pin driver enable, low drives
  output wire [NISM-1:0] ism_out // Input matrix outputs
);
  reg awready_reg;
  reg wready_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;
  reg [11:0] awa_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  reg [12:0] ctrl_reg;
  reg [2:0] pincfg_reg;
  reg [11:0] mccfg_reg [0:15];
  reg [2:0] clcfg_reg [0:15];
  reg [29:0] ismsel_reg [0:3];
  reg [NIN-1:0] tm_reg [0:89];
  reg [NIN-1:0] cm_reg [0:89];

  reg [NIN-1:0] csm_s1_reg;
  reg [NIN-1:0] csm_s2_reg;
  reg [3:0] gclk_s1_reg;
  reg [3:0] gclk_s2_reg;
  reg [7:0] pin_s1_reg;
  reg [7:0] pin_s2_reg;
  reg [3:0] bclk_reg;
  reg [3:0] bclk_d_reg;
  reg [7:0] pinq_reg;
  reg [7:0] pin_o_reg;
  reg [7:0] pin_oe_n_reg;
  reg [NISM-1:0] ism_reg;

  wire [89:0] pt;
  wire [15:0] mc_out;
  wire [31:0] ism_src;
  wire init_pre;
  wire init_rst;
  reg [15:0] sum_v;
  reg [15:0] xterm_v;

  integer i;
  integer j;
  integer n;
  integer k;
  integer dk;
  reg [4:0] p;
  reg [4:0] rsv;
  reg [4:0] dm;
  reg [4:0] om;
  reg xk;

  function [2:0] reg_kind;
    input [11:0] a;
    reg [11:0] w;
    begin
      w = {a[11:2], 2'h0};
      if (w == `OFF_CTRL) begin
        reg_kind = `K_CTRL;
      end else if (w == `OFF_STATUS) begin
        reg_kind = `K_STATUS;
      end else if (w == `OFF_PINCFG) begin
        reg_kind = `K_PINCFG;
      end else if ((w & 12'hfc0) == `OFF_MCCFG) begin
        reg_kind = `K_MC;
      end else if ((w & 12'hfc0) == `OFF_CLCFG) begin
        reg_kind = `K_CL;
      end else if ((w & 12'hff0) == `OFF_ISMSEL) begin
        reg_kind = `K_ISM;
      end else if (w >= `OFF_TERM && w < `TERM_END && w[3:2] != 2'h3) begin
        reg_kind = `K_TERM;
      end else begin
        reg_kind = `K_NONE;
      end
    end
  endfunction

  function [6:0] term_idx;
    input [11:0] a;
    reg [11:0] t;
    begin
      t = a - `OFF_TERM;
      term_idx = t[10:4];
    end
  endfunction

  function [31:0] reg_word;
    input [11:0] a;
    reg [6:0] ti;
    begin
      ti = term_idx(a);
      case (reg_kind(a))
        `K_CTRL: reg_word = {19'h0, ctrl_reg};
        `K_STATUS: reg_word = {mc_out, pin_s2_reg, gclk_s2_reg, bclk_reg};
        `K_PINCFG: reg_word = {29'h0, pincfg_reg};
        `K_MC: reg_word = {20'h0, mccfg_reg[a[5:2]]};
        `K_CL: reg_word = {29'h0, clcfg_reg[a[5:2]]};
        `K_ISM: reg_word = {2'h0, ismsel_reg[a[3:2]]};
        `K_TERM: begin
          if (a[3:2] == 2'h0) begin
            reg_word = tm_reg[ti][31:0];
          end else if (a[3:2] == 2'h1) begin
            reg_word = cm_reg[ti][31:0];
          end else begin
            reg_word = {30'h0, cm_reg[ti][32], tm_reg[ti][32]};
          end
        end
        default: reg_word = 32'h0;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[8*b +: 8] = nw[8*b +: 8];
        end
      end
    end
  endfunction

  // A term with no literals would be a constant one; forcing it low keeps idle clusters out
  function term_val;
    input [NIN-1:0] tm;
    input [NIN-1:0] cm;
    input [NIN-1:0] x;
    begin
      term_val = (|(tm | cm)) & (&(~tm | x)) & (&(~cm | ~x));
    end
  endfunction

  // Steering code 0 own cell, 1 cell below, 2 cell above, 3 two below; off the ends stays home
  function integer cl_dest;
    input integer c;
    input [1:0] s;
    integer d;
    begin
      case (s)
        2'h0: d = c;
        2'h1: d = c - 1;
        2'h2: d = c + 1;
        default: d = c - 2;
      endcase
      cl_dest = (d < 0 || d > 15) ? c : d;
    end
  endfunction

  wire [31:0] wr_val = merge(reg_word(awa_reg), wdata_reg, wstrb_reg);
  wire [6:0] wr_ti = term_idx(awa_reg);
  // Register bus; config only changes by software writes and is otherwise static
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h0;
      awa_reg <= 12'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      ctrl_reg <= `RST_CTRL;
      pincfg_reg <= `RST_PINCFG;
      for (i = 0; i < 16; i = i + 1) begin
        mccfg_reg[i] <= `RST_MCCFG;
        clcfg_reg[i] <= `RST_CLCFG;
      end
      for (i = 0; i < 4; i = i + 1) begin
        ismsel_reg[i] <= `RST_ISMSEL;
      end
      for (i = 0; i < 90; i = i + 1) begin
        tm_reg[i] <= {NIN{1'b0}};
        cm_reg[i] <= {NIN{1'b0}};
      end
    end else begin
      if (awready_reg && s_axi_awvalid) begin
        awready_reg <= 1'b0;
        awa_reg <= s_axi_awaddr;
      end
      if (wready_reg && s_axi_wvalid) begin
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (!awready_reg && !wready_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
        bvalid_reg <= 1'b1;
        bresp_reg <= `RESP_OKAY;
        case (reg_kind(awa_reg))
          `K_CTRL: ctrl_reg <= wr_val[12:0];
          `K_PINCFG: pincfg_reg <= wr_val[2:0];
          `K_MC: mccfg_reg[awa_reg[5:2]] <= wr_val[11:0];
          `K_CL: clcfg_reg[awa_reg[5:2]] <= wr_val[2:0];
          `K_ISM: ismsel_reg[awa_reg[3:2]] <= wr_val[29:0];
          `K_TERM: begin
            if (awa_reg[3:2] == 2'h0) begin
              tm_reg[wr_ti][31:0] <= wr_val;
            end else if (awa_reg[3:2] == 2'h1) begin
              cm_reg[wr_ti][31:0] <= wr_val;
            end else begin
              tm_reg[wr_ti][32] <= wr_val[0];
              cm_reg[wr_ti][32] <= wr_val[1];
            end
          end
          `K_STATUS: bresp_reg <= `RESP_OKAY;
          default: bresp_reg <= `RESP_SLVERR;
        endcase
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (arready_reg && s_axi_arvalid) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= reg_word(s_axi_araddr);
        rresp_reg <= (reg_kind(s_axi_araddr) == `K_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // Pins and clock pins are asynchronous to aclk
  always @(posedge aclk) begin
    if (!aresetn) begin
      csm_s1_reg <= {NIN{1'b0}};
      csm_s2_reg <= {NIN{1'b0}};
      gclk_s1_reg <= 4'h0;
      gclk_s2_reg <= 4'h0;
      pin_s1_reg <= 8'h0;
      pin_s2_reg <= 8'h0;
    end else begin
      csm_s1_reg <= csm_in;
      csm_s2_reg <= csm_s1_reg;
      gclk_s1_reg <= gclk_pin;
      gclk_s2_reg <= gclk_s1_reg;
      pin_s1_reg <= pin_i;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Clock generator
  always @(posedge aclk) begin
    if (!aresetn) begin
      bclk_reg <= 4'h0;
      bclk_d_reg <= 4'h0;
    end else begin
      for (n = 0; n < 4; n = n + 1) begin
        bclk_reg[n] <= gclk_s2_reg[ctrl_reg[3*n +: 2]] ^ ctrl_reg[3*n+2];
      end
      bclk_d_reg <= bclk_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 90; g = g + 1) begin : gen_term
      assign pt[g] = term_val(tm_reg[g], cm_reg[g], csm_s2_reg);
    end
  endgenerate

  assign init_pre = ctrl_reg[`CTRL_SWAP] ? pt[`INIT_B] : pt[`INIT_A];
  assign init_rst = ctrl_reg[`CTRL_SWAP] ? pt[`INIT_A] : pt[`INIT_B];

  // Logic allocator; async cells reserve own terms 3 and 4 for clock and init
  always @* begin
    sum_v = 16'h0;
    xterm_v = 16'h0;
    p = 5'h0;
    rsv = 5'h0;
    dm = 5'h0;
    om = 5'h0;
    xk = 1'b0;
    dk = 0;
    for (k = 0; k < 16; k = k + 1) begin
      p = pt[5*k +: 5];
      rsv = mccfg_reg[k][`MC_ASYNC] ? 5'h18 : 5'h00;
      xk = mccfg_reg[k][`MC_XOR] | (mccfg_reg[k][`MC_REG] & mccfg_reg[k][`MC_TYPE+1]);
      dk = cl_dest(k, clcfg_reg[k][1:0]);
      if (dk == k) begin
        dm = ~rsv & ~{4'h0, xk};
        om = 5'h0;
      end else begin
        dm = (clcfg_reg[k][`CL_KEEP] ? 5'h1e : 5'h1f) & ~rsv;
        om = clcfg_reg[k][`CL_KEEP] ? {4'h0, ~xk} : 5'h00;
      end
      sum_v[dk] = sum_v[dk] | (|(p & dm));
      sum_v[k] = sum_v[k] | (|(p & om));
      xterm_v[k] = xk & p[0] & ((dk == k) | clcfg_reg[k][`CL_KEEP]);
    end
  end

  generate
    for (g = 0; g < 16; g = g + 1) begin : gen_cell
      macrocell u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(mccfg_reg[g]),
        .sum(sum_v[g]),
        .xterm(xterm_v[g]),
        .bclk(bclk_reg),
        .ptclk(pt[5*g+3]),
        .ptinit(pt[5*g+4]),
        .init_pre(init_pre),
        .init_rst(init_rst),
        .q_out(mc_out[g])
      );
    end
  endgenerate

  assign ism_src = {pin_s2_reg, pinq_reg, mc_out};

  // Pin cells; pin p is fed by cell 2p as the output matrix is not modelled
  always @(posedge aclk) begin
    if (!aresetn) begin
      pinq_reg <= 8'h0;
      pin_o_reg <= 8'h0;
      pin_oe_n_reg <= 8'hff;
      ism_reg <= {NISM{1'b0}};
    end else begin
      if (pincfg_reg[`PIN_LATCH] ? bclk_reg[pincfg_reg[1:0]] :
          (bclk_reg[pincfg_reg[1:0]] & ~bclk_d_reg[pincfg_reg[1:0]])) begin
        pinq_reg <= pin_s2_reg;
      end
      for (j = 0; j < 8; j = j + 1) begin
        pin_o_reg[j] <= mc_out[2*j];
        pin_oe_n_reg[j] <= ~pt[`OE_BASE+j];
      end
      for (j = 0; j < NISM; j = j + 1) begin
        ism_reg[j] <= ism_src[ismsel_reg[j/6][(j%6)*5 +: 5]];
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign pin_o = pin_o_reg;
  assign pin_oe_n = pin_oe_n_reg;
  assign ism_out = ism_reg;
endmodule // logic_block
`default_nettype wire

// ===== rtl/logic_block_defs.vh
`ifndef LOGIC_BLOCK_DEFS_VH
`define LOGIC_BLOCK_DEFS_VH
// Functional notes
// - Device-wide, 64 I/O pins and 6 inputs feed the central matrix for all eight blocks.
// - Four global clock pins, each also usable as a plain logic input.
// - Block holds clock generator, 90-term array, allocator, 16 cells, output matrix, 8 pins; the output matrix is not modelled, pin p takes cell 2p.
// - Central matrix gives each block exactly 33 input signals.
// - Array has 80 logic terms, eight output-enable terms, two initialization terms.
// - Each pin driver has its own output-enable term.
// - Synchronous-mode flops of a block initialize together on either init term.
// - Input matrix is offered 16 cell feedbacks, 8 registered pins, 8 direct pins.
// - Input matrix forwards 24 of those 32 signals to the central matrix.
// - Clock generator makes four block clocks usable in both cell modes.
// - Each block clock picks true or inverted form of one global clock pin.
// - Each cell nominally owns a cluster of 5 logic terms, redistributable.
// - A cell collects at most 20 terms synchronous, 18 asynchronous.
// - Steering away moves all 5 terms, or 4 keeping one for the cell; an async cell's terms 3 and 4 never move.
// - Each cell path has an XOR gate for logic and flop emulation.
// - Cell n reaches clusters n-1 to n+2, clipped at both ends.
// - Each cell picks synchronous or asynchronous mode independently.
// - Cell output registered or combinational, with programmable polarity.
// - Registered cell acts as D, T, J-K, S-R flop or transparent latch.
// - Sync cells use a block clock; async cells may use a term clock, either edge.
// - Sync init terms drive preset and reset; a swap bit exchanges them.
// - Async cell uses its own term for either reset or preset.
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_PINCFG 12'h008
`define OFF_MCCFG 12'h040
`define OFF_CLCFG 12'h080
`define OFF_ISMSEL 12'h0c0
`define OFF_TERM 12'h400
`define TERM_END 12'h9a0
`define RST_CTRL 13'h0688
`define RST_PINCFG 3'h0
`define RST_MCCFG 12'h000
`define RST_CLCFG 3'h0
`define RST_ISMSEL 30'h0
`define CTRL_SWAP 12
`define PIN_LATCH 2
`define MC_ASYNC 0
`define MC_REG 1
`define MC_INV 2
`define MC_TYPE 3
`define MC_LATCH 5
`define MC_BCLK 6
`define MC_PTEDGE 8
`define MC_APRE 9
`define MC_PTCLK 10
`define MC_XOR 11
`define CL_KEEP 2
`define FF_D 2'h0
`define FF_T 2'h1
`define FF_JK 2'h2
`define FF_SR 2'h3
`define OE_BASE 80
`define INIT_A 88
`define INIT_B 89
`define K_NONE 3'h0
`define K_CTRL 3'h1
`define K_STATUS 3'h2
`define K_PINCFG 3'h3
`define K_MC 3'h4
`define K_CL 3'h5
`define K_ISM 3'h6
`define K_TERM 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== rtl/macrocell.v
`timescale 1ns/1ps
`default_nettype none
`include "logic_block_defs.vh"
module macrocell (
  input wire aclk, // System clock
  input wire aresetn, // Synchronous reset, active low
  input wire [11:0] cfg, // Static cell configuration
  input wire sum, // Allocated sum of terms
  input wire xterm, // Second operand: XOR or K/R input
  input wire [3:0] bclk, // Block clock levels
  input wire ptclk, // Own term clock
  input wire ptinit, // Own term initialization
  input wire init_pre, // Block preset term
  input wire init_rst, // Block reset term
  output wire q_out // Cell output after polarity
);
  wire async = cfg[`MC_ASYNC];
  wire clk_lvl = (async & cfg[`MC_PTCLK]) ? (ptclk ^ cfg[`MC_PTEDGE]) :
    bclk[cfg[`MC_BCLK+1:`MC_BCLK]];
  wire xe = cfg[`MC_XOR] & xterm;
  wire d = sum ^ xe;
  wire rst = async ? (ptinit & ~cfg[`MC_APRE]) : init_rst;
  wire pre = async ? (ptinit & cfg[`MC_APRE]) : init_pre;
  reg q_reg;
  reg lvl_d_reg;
  reg q_next;

  always @* begin
    case (cfg[`MC_TYPE+1:`MC_TYPE])
      `FF_D: q_next = d;
      `FF_T: q_next = q_reg ^ d;
      `FF_JK: q_next = (sum & ~q_reg) | (~xterm & q_reg);
      default: q_next = sum | (q_reg & ~xterm);
    endcase
  end

  // Init does not wait for the cell clock; reset wins if both terms fire
  always @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= 1'b0;
      lvl_d_reg <= 1'b0;
    end else begin
      lvl_d_reg <= clk_lvl;
      if (rst) begin
        q_reg <= 1'b0;
      end else if (pre) begin
        q_reg <= 1'b1;
      end else if (cfg[`MC_LATCH]) begin
        if (clk_lvl) begin
          q_reg <= d;
        end
      end else if (clk_lvl & ~lvl_d_reg) begin
        q_reg <= q_next;
      end
    end
  end

  assign q_out = (cfg[`MC_REG] ? q_reg : d) ^ cfg[`MC_INV];
endmodule // macrocell
`default_nettype wire

// ===== sim/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input wire logic [7:0] pin_o, // Block pin values
  input wire logic [7:0] pin_oe_n, // Block drive enables, low drives
  input wire logic [7:0] ext_en, // Board drives the pin
  input wire logic [7:0] ext_val, // Board pin value
  output logic [7:0] pin_i // Wire level seen by the block
);
  // Pull-ups lift a pin that nobody drives
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      pin_i[p] = !pin_oe_n[p] ? pin_o[p] : (ext_en[p] ? ext_val[p] : 1'b1);
    end
  end
endmodule // board_model
`default_nettype wire

// ===== sim/logic_block_props.sv
`timescale 1ns/1ps
`default_nettype none
module logic_block_props #(
  parameter NISM = 24 // Input matrix outputs
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [7:0] pin_o, // Pin values
  input wire logic [7:0] pin_oe_n, // Pin enables, low drives
  input wire logic [NISM-1:0] ism_out // Input matrix outputs
);
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Reset values are visible at the first edge after release
  AST_OE_IDLE: assert property ($rose(aresetn) |-> pin_oe_n == 8'hff && pin_o == 8'h00)
    else $error("pin drivers not idle after reset");
  AST_OUT_IDLE: assert property ($rose(aresetn) |-> ism_out == '0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  AST_WR_RESP: assert property (wr_take && !s_axi_bvalid |=> !s_axi_awready ##1 s_axi_bvalid && s_axi_wready)
    else $error("write response late or channels not blocked");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not retired");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready && s_axi_awready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  COV_WR_ERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  COV_RD_ERR: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  COV_PIN_DRIVE: cover property (pin_oe_n[0] == 1'b0);
endmodule // logic_block_props
bind logic_block logic_block_props #(.NISM(NISM)) props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .ism_out(ism_out));
`default_nettype wire

// ===== sim/tb_logic_block.sv
`timescale 1ns/1ps
`default_nettype none
`include "logic_block_defs.vh"
module tb_logic_block;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awrdy, wrdy, bvld, arrdy, rvld;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, s;
  logic [1:0] bresp, rresp, r;
  logic [32:0] csm_in;
  logic [3:0] gclk_pin;
  logic [7:0] pin_i, pin_o, pin_oe_n, ext_en, ext_val;
  logic [23:0] ism_out;
  int err_count, n_tests;
  logic_block DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvld), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rready), .csm_in(csm_in),
    .gclk_pin(gclk_pin), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .ism_out(ism_out));
  board_model board (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ready is raised only after the answer shows, so the slave must hold it
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, wd;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awrdy) ad = 1'b1;
      if (wvalid && wrdy) wd = 1'b1;
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    while (!bvld) @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!arrdy);
    arvalid <= 1'b0;
    while (!rvld) @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, s);
    chk("rdata", e, s);
    chk("rresp", er, r);
  endtask
  task automatic stat(input logic [32:0] c);
    csm_in <= c;
    repeat (3) @(posedge aclk);
    rd(`OFF_STATUS, s);
  endtask
  task automatic tick(input logic [32:0] c);
    gclk_pin <= 4'h1;
    repeat (6) @(posedge aclk);
    gclk_pin <= 4'h0;
    stat(c);
  endtask
  task automatic t_regs;
    rc(`OFF_CTRL, 32'h688, `RESP_OKAY);
    rc(`OFF_MCCFG, 32'h0, `RESP_OKAY);
    wr(`OFF_MCCFG + 12'h03c, 32'hf02, `RESP_OKAY);
    rc(`OFF_MCCFG + 12'h03c, 32'hf02, `RESP_OKAY);
    wr(`OFF_MCCFG + 12'h03c, 32'h0, `RESP_OKAY);
    wr(`OFF_TERM + 12'h00c, 32'h1, `RESP_SLVERR);
    rc(`OFF_TERM + 12'h00c, 32'h0, `RESP_SLVERR);
    wr(`OFF_STATUS, 32'hffffffff, `RESP_OKAY);
  endtask
  task automatic t_clk;
    for (int k = 0; k < 2; k++) begin
      wr(`OFF_CTRL, k ? 32'h977 : 32'h688, `RESP_OKAY);
      for (int v = 0; v < 16; v += 5) begin
        gclk_pin <= v[3:0];
        repeat (4) @(posedge aclk);
        rd(`OFF_STATUS, s);
        chk("gclk_sync", v[3:0], s[7:4]);
        chk("bclk", k ? {v[0], v[1], v[2], v[3]} ^ 4'hf : v[3:0], s[3:0]);
      end
    end
    gclk_pin <= 4'h0;
    wr(`OFF_CTRL, 32'h688, `RESP_OKAY);
  endtask
  task automatic t_logic;
    wr(`OFF_TERM, 32'h1, `RESP_OKAY);
    wr(`OFF_TERM + 12'h008, 32'h1, `RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      wr(`OFF_MCCFG, k[2] ? 32'h4 : 32'h0, `RESP_OKAY);
      stat({k[1], 31'h0, k[0]});
      chk("mc_out", (k[1] & k[0]) ^ k[2], s[31:16]);
      chk("pin_o", (k[1] & k[0]) ^ k[2], pin_o);
    end
    wr(`OFF_MCCFG, 32'h0, `RESP_OKAY);
  endtask
  task automatic t_alloc;
    logic [31:0] cv [4] = '{32'h3, 32'h7, 32'h2, 32'h1};
    logic [15:0] ev [4] = '{16'h8001, 16'h8004, 16'h8004, 16'h4004};
    wr(`OFF_TERM + 12'h0a0, 32'h4, `RESP_OKAY);
    wr(`OFF_TERM + 12'h4b0, 32'h8, `RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      wr(`OFF_CLCFG + (k < 2 ? 12'h008 : 12'h03c), cv[k], `RESP_OKAY);
      stat(33'hc);
      chk("mc_out", ev[k], s[31:16]);
    end
  endtask
  task automatic t_xor;
    wr(`OFF_MCCFG + 12'h010, 32'h800, `RESP_OKAY);
    wr(`OFF_TERM + 12'h140, 32'h10, `RESP_OKAY);
    wr(`OFF_TERM + 12'h150, 32'h20, `RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      stat({27'h0, k[1:0], 4'h0});
      chk("xor", k[0] ^ k[1], s[20]);
    end
  endtask
  // Cell 6 synchronous, cell 8 asynchronous: block init must touch cell 6 only
  task automatic t_reg;
    wr(`OFF_MCCFG + 12'h018, 32'h2, `RESP_OKAY);
    wr(`OFF_MCCFG + 12'h020, 32'h3, `RESP_OKAY);
    wr(`OFF_TERM + 12'h1e0, 32'h40, `RESP_OKAY);
    wr(`OFF_TERM + 12'h280, 32'h40, `RESP_OKAY);
    wr(`OFF_TERM + 12'h580, 32'h80, `RESP_OKAY);
    wr(`OFF_TERM + 12'h590, 32'h100, `RESP_OKAY);
    stat(33'h40);
    tick(33'h40);
    chk("d_capture", 2'h3, {s[24], s[22]});
    stat(33'h100);
    chk("init_reset", 2'h2, {s[24], s[22]});
    stat(33'h80);
    chk("init_preset", 2'h3, {s[24], s[22]});
    wr(`OFF_CTRL, 32'h1688, `RESP_OKAY);
    stat(33'h80);
    chk("init_swap", 2'h2, {s[24], s[22]});
    wr(`OFF_MCCFG + 12'h018, 32'ha, `RESP_OKAY);
    stat(33'h40);
    for (int k = 1; k < 3; k++) begin
      tick(33'h40);
      chk("toggle", k & 1, s[22]);
    end
  endtask
  task automatic t_pins;
    logic [32:0] c [4] = '{33'h0, 33'h0, 33'h200, 33'h1_0000_0201};
    wr(`OFF_TERM + 12'h500, 32'h200, `RESP_OKAY);
    wr(`OFF_ISMSEL, 32'h18, `RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      ext_en <= {7'h0, k == 1};
      stat(c[k]);
      repeat (4) @(posedge aclk);
      chk("pin_oe_n", k > 1 ? 8'hfe : 8'hff, pin_oe_n);
      // Pin 4 follows cell 8, which still holds the one it captured in the register scenario
      chk("pin_o", {3'h0, 1'b1, 3'h0, k == 3}, pin_o);
      chk("ism_out", k == 3 ? 24'hffffff : {23'h0, k == 0}, ism_out);
    end
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, csm_in, gclk_pin, ext_en, ext_val} = '0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_clk;
    t_logic;
    t_alloc;
    t_xor;
    t_reg;
    t_pins;
    summarize;
  end
  // Whole run needs a few hundred cycles
  initial begin
    #200us;
    err_count++;
    summarize;
  end
endmodule // tb_logic_block
`default_nettype wire
